// *** hdl/pspp_pixel_path.sv ***
// Pixel combine datapath: pattern and source expansion, transparency, ternary op.
// Assumes a register port and a pixel stream, both on the single core clock.
//
// Notes on behaviour
// - Mode 11b uses pattern bits as colour pixels.
// - 8-bpp colour row: low 64 bits, byte0 leftmost.
// - 16-bpp colour row: all 128 bits, halfword0 leftmost.
// - Source bit 0 picks colour zero, 1 colour one.
// - Source transparency drops expanded source pixels with source bit clear.
// - Output bit indexes op code by pattern-source-destination.
// - F0 pattern, CC source, 5A, 66 XORs, 55 invert.
// - Parameter registers span 200h locations from 8100h.
// - First register holds destination or vector start.
// - Size register: width/height or error/length.
// - Source register: source X/Y or error terms.
// - Four pattern words give 128 bits, word0 lowest.
// - Four pattern colours, two per register, expand patterns.
// - Mode 01b: bit 0 colour zero, 1 colour one.
// - Mode 10b: two bits pick four colours.
// - Pattern transparency drops clear monochrome pattern pixels.
`timescale 1ns/100ps
module pspp_pixel_path #(
  parameter int PIXEL_W = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  // Register port: byte address, strobes and data.
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Parameters handed to the walking engine.
  output logic [31:0] destination_start_coords,
  output logic [31:0] size_or_vector_length,
  output logic [31:0] source_coords_or_errors,
  // Pixel stream in.
  input wire logic px_valid,
  input wire logic [2:0] px_col,
  input wire logic [2:0] px_row,
  input wire logic px_bpp16,
  input wire logic px_src_expand,
  input wire logic px_src_bit,
  input wire logic [PIXEL_W-1:0] px_src_pixel,
  input wire logic [PIXEL_W-1:0] px_dst_pixel,
  // Pixel stream out.
  output logic out_valid,
  output logic out_write,
  output logic [PIXEL_W-1:0] out_pixel
);

  // The pattern layout assumes sixteen-bit pixels; other widths are refused.
  if (PIXEL_W != 16)
  begin : g_width_check
    $error("pspp_pixel_path supports only PIXEL_W of 16.");
  end

  // Every stored slot needs a code below the unmapped code.
  if (pspp_pkg::NUM_STORED >= 15)
  begin : g_slot_check
    $error("pspp_pixel_path has more stored registers than slot codes.");
  end

  // Maps a byte address to a storage slot, or to none.
  function automatic logic [3:0] slot_of(input logic [15:0] a);
    logic [3:0] s;
    s = pspp_pkg::IDX_NONE;
    // Anything outside the window or off word alignment is unmapped.
    if (a >= pspp_pkg::WIN_BASE && a < pspp_pkg::WIN_BASE + pspp_pkg::WIN_SIZE
        && a[1:0] == 2'b00)
    begin
      case (a)
        pspp_pkg::OFS_DST_COORDS: s = pspp_pkg::IDX_DST;
        pspp_pkg::OFS_SIZE_LEN: s = pspp_pkg::IDX_SIZE;
        pspp_pkg::OFS_SRC_COORDS: s = pspp_pkg::IDX_SRC;
        pspp_pkg::OFS_SRC_COLORS: s = pspp_pkg::IDX_SRC_COL;
        pspp_pkg::OFS_PAT_COLORS_LO: s = pspp_pkg::IDX_PAT_LO;
        pspp_pkg::OFS_PAT_COLORS_HI: s = pspp_pkg::IDX_PAT_HI;
        pspp_pkg::OFS_PAT_WORD0: s = pspp_pkg::IDX_PAT0;
        pspp_pkg::OFS_PAT_WORD1: s = pspp_pkg::IDX_PAT1;
        pspp_pkg::OFS_PAT_WORD2: s = pspp_pkg::IDX_PAT2;
        pspp_pkg::OFS_PAT_WORD3: s = pspp_pkg::IDX_PAT3;
        pspp_pkg::OFS_COMBINE_CTRL: s = pspp_pkg::IDX_CTRL;
        pspp_pkg::OFS_WRITE_COUNT: s = pspp_pkg::IDX_COUNT;
        // Holes inside the window, such as 8118h, read as unmapped.
        default: s = pspp_pkg::IDX_NONE;
      endcase
    end
    return s;
  endfunction

  // Writable register storage, one word per slot.
  logic [31:0] regs_q [0:pspp_pkg::NUM_STORED-1];
  // Count of pixels that were written out.
  logic [31:0] write_count_q;
  // Slot addressed by the current access.
  logic [3:0] acc_slot;

  assign acc_slot = slot_of(reg_addr);

  // Register writes honour byte enables; the counter is read only.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // All slots clear together, so no stale parameter survives a reset.
      for (int i = 0; i < pspp_pkg::NUM_STORED; i++)
      begin
        regs_q[i] <= pspp_pkg::REG_RESET;
      end
    end
    // Unmapped addresses and the read-only counter fall through here.
    else if (reg_wr && acc_slot < 4'(pspp_pkg::NUM_STORED))
    begin
      // Each enabled byte lane replaces its byte.
      for (int k = 0; k < 4; k++)
      begin
        if (reg_be[k])
        begin
          regs_q[acc_slot][8*k +: 8] <= reg_wdata[8*k +: 8];
        end
      end
    end
  end

  // Read data is registered and answered one cycle after the strobe.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        // Unmapped addresses read as zero.
        // A read beside an increment returns the count before it.
        if (acc_slot == pspp_pkg::IDX_COUNT)
        begin
          reg_rdata <= write_count_q;
        end
        else if (acc_slot < 4'(pspp_pkg::NUM_STORED))
        begin
          reg_rdata <= regs_q[acc_slot];
        end
        else
        begin
          reg_rdata <= 32'h0000_0000;
        end
      end
    end
  end

  // Coordinate, size and source words go to the walking engine unchanged.
  assign destination_start_coords = regs_q[pspp_pkg::IDX_DST];
  assign size_or_vector_length = regs_q[pspp_pkg::IDX_SIZE];
  assign source_coords_or_errors = regs_q[pspp_pkg::IDX_SRC];

  // Control fields.
  logic [7:0] ternary_op_code;
  pspp_pkg::pspp_pat_mode_type pat_mode;
  logic pat_transp;
  logic src_transp;

  assign ternary_op_code = regs_q[pspp_pkg::IDX_CTRL][pspp_pkg::CTRL_OP_LSB +: 8];
  assign pat_mode = pspp_pkg::pspp_pat_mode_type'(
    regs_q[pspp_pkg::IDX_CTRL][pspp_pkg::CTRL_MODE_LSB +: 2]);
  assign pat_transp = regs_q[pspp_pkg::IDX_CTRL][pspp_pkg::CTRL_PAT_TRANSP];
  assign src_transp = regs_q[pspp_pkg::IDX_CTRL][pspp_pkg::CTRL_SRC_TRANSP];

  // The 128 pattern bits, word0 in the lowest bits.
  logic [127:0] pattern_bits;

  assign pattern_bits = {regs_q[pspp_pkg::IDX_PAT3], regs_q[pspp_pkg::IDX_PAT2],
                         regs_q[pspp_pkg::IDX_PAT1], regs_q[pspp_pkg::IDX_PAT0]};

  // Colour values, low halfword first in each register.
  logic [15:0] source_color_zero;
  logic [15:0] source_color_one;
  logic [15:0] pattern_color_zero;
  logic [15:0] pattern_color_one;
  logic [15:0] pattern_color_two;
  logic [15:0] pattern_color_three;

  // Source colour zero sits at 810Ch and colour one at 810Eh.
  assign source_color_zero = regs_q[pspp_pkg::IDX_SRC_COL][15:0];
  assign source_color_one = regs_q[pspp_pkg::IDX_SRC_COL][31:16];
  assign pattern_color_zero = regs_q[pspp_pkg::IDX_PAT_LO][15:0];
  assign pattern_color_one = regs_q[pspp_pkg::IDX_PAT_LO][31:16];
  assign pattern_color_two = regs_q[pspp_pkg::IDX_PAT_HI][15:0];
  assign pattern_color_three = regs_q[pspp_pkg::IDX_PAT_HI][31:16];

  // Bit positions of the current pixel inside the pattern.
  logic [6:0] mono_pos;
  logic [6:0] dith_lo_pos;
  logic [6:0] dith_hi_pos;

  // Bit of a column inside a pattern byte; bit 7 is the leftmost pixel.
  function automatic logic [2:0] col_bit(input logic [2:0] col);
    logic [2:0] pos;
    pos = 3'h7 - col;
    return pos;
  endfunction

  // Mono rows are bytes; the byte's bit 7 is the leftmost pixel.
  assign mono_pos = {1'b0, px_row, col_bit(px_col)};
  // Dither rows are halfwords: low byte least, high byte most significant bit.
  assign dith_lo_pos = {px_row, 1'b0, col_bit(px_col)};
  assign dith_hi_pos = {px_row, 1'b1, col_bit(px_col)};

  // Expanded pattern colour and its transparency for this pixel.
  logic [15:0] pat_pixel;
  logic pat_keep;

  // Pattern expansion chosen by the two-bit mode.
  always_comb
  begin
    pat_pixel = pattern_color_zero;
    pat_keep = 1'b1;
    case (pat_mode)
      pspp_pkg::PSPP_PAT_SOLID:
      begin
        // Solid fills always take colour zero.
        pat_pixel = pattern_color_zero;
      end
      pspp_pkg::PSPP_PAT_MONO:
      begin
        // One bit picks between two colours.
        pat_pixel = pattern_bits[mono_pos] ? pattern_color_one
                                           : pattern_color_zero;
        // Clear bits are dropped while transparency is on.
        pat_keep = !pat_transp || pattern_bits[mono_pos];
      end
      pspp_pkg::PSPP_PAT_DITHER:
      begin
        // Two bits pick one of four colours.
        // Pattern transparency does not apply to dither patterns.
        case ({pattern_bits[dith_hi_pos], pattern_bits[dith_lo_pos]})
          2'b00: pat_pixel = pattern_color_zero;
          2'b01: pat_pixel = pattern_color_one;
          2'b10: pat_pixel = pattern_color_two;
          default: pat_pixel = pattern_color_three;
        endcase
      end
      pspp_pkg::PSPP_PAT_COLOR:
      begin
        // The pattern bits are the pixels of a single row.
        // The row input is ignored; software reloads each row.
        if (px_bpp16)
        begin
          pat_pixel = pattern_bits[16*px_col +: 16];
        end
        else
        begin
          pat_pixel = {8'h00, pattern_bits[8*px_col +: 8]};
        end
      end
      default:
      begin
        pat_pixel = pattern_color_zero;
      end
    endcase
  end

  // Source pixel after colour expansion, and its transparency.
  logic [15:0] src_pixel;
  logic src_keep;

  // Monochrome source expands to two colours when requested.
  always_comb
  begin
    if (px_src_expand)
    begin
      src_pixel = px_src_bit ? source_color_one : source_color_zero;
      src_keep = !src_transp || px_src_bit;
    end
    else
    begin
      // Colour source data passes unchanged and is never transparent.
      src_pixel = px_src_pixel;
      src_keep = 1'b1;
    end
  end

  // At 8 bpp only the low byte of each operand takes part.
  logic [15:0] depth_mask;
  logic [15:0] op_result;

  // Masking the result keeps the upper output byte at zero at 8 bpp; masked operands alone do not, since op code bit 0 fills it.
  assign depth_mask = px_bpp16 ? 16'hFFFF : 16'h00FF;

  // Ternary combine of pattern, source and destination.
  // The op code is read live, so a control write acts on the next pixel.
  pspp_ternary_op #(
    .WIDTH(16)
  ) u_op (
    .ternary_op_code(ternary_op_code),
    .pat_word(pat_pixel & depth_mask),
    .src_word(src_pixel & depth_mask),
    .dst_word(px_dst_pixel & depth_mask),
    .result_word(op_result)
  );

  // Output stage: one cycle after the input pixel.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_valid <= 1'b0;
      out_write <= 1'b0;
      out_pixel <= 16'h0000;
    end
    else
    begin
      // Every taken pixel gets exactly one result, one cycle later.
      out_valid <= px_valid;
      // A pixel is written only if neither transparency drops it.
      out_write <= px_valid && pat_keep && src_keep;
      // Idle cycles keep the last result so the pixel output stands still.
      if (px_valid)
      begin
        out_pixel <= op_result & depth_mask;
      end
    end
  end

  // Counts the pixels actually written, for software to observe.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      write_count_q <= 32'h0000_0000;
    end
    // The tally wraps to zero after its largest value.
    else if (out_write)
    begin
      write_count_q <= write_count_q + 32'h0000_0001;
    end
  end

endmodule

// *** hdl/pspp_pkg.sv ***
// Constants for the pixel combine datapath: register map, control fields, modes.
// Assumes one core clock and a word-wide register port in the graphics window.
package pspp_pkg;

  // Window of the pipeline parameter registers.
  localparam logic [15:0] WIN_BASE = 16'h8100;
  localparam logic [15:0] WIN_SIZE = 16'h0200;

  // Register byte offsets within the device map.
  localparam logic [15:0] OFS_DST_COORDS = 16'h8100;
  localparam logic [15:0] OFS_SIZE_LEN = 16'h8104;
  localparam logic [15:0] OFS_SRC_COORDS = 16'h8108;
  localparam logic [15:0] OFS_SRC_COLORS = 16'h810C;
  localparam logic [15:0] OFS_PAT_COLORS_LO = 16'h8110;
  localparam logic [15:0] OFS_PAT_COLORS_HI = 16'h8114;
  localparam logic [15:0] OFS_PAT_WORD0 = 16'h8120;
  localparam logic [15:0] OFS_PAT_WORD1 = 16'h8124;
  localparam logic [15:0] OFS_PAT_WORD2 = 16'h8128;
  localparam logic [15:0] OFS_PAT_WORD3 = 16'h812C;
  localparam logic [15:0] OFS_COMBINE_CTRL = 16'h8200;
  localparam logic [15:0] OFS_WRITE_COUNT = 16'h8220;

  // Storage slots of the register array.
  localparam logic [3:0] IDX_DST = 4'h0;
  localparam logic [3:0] IDX_SIZE = 4'h1;
  localparam logic [3:0] IDX_SRC = 4'h2;
  localparam logic [3:0] IDX_SRC_COL = 4'h3;
  localparam logic [3:0] IDX_PAT_LO = 4'h4;
  localparam logic [3:0] IDX_PAT_HI = 4'h5;
  localparam logic [3:0] IDX_PAT0 = 4'h6;
  localparam logic [3:0] IDX_PAT1 = 4'h7;
  localparam logic [3:0] IDX_PAT2 = 4'h8;
  localparam logic [3:0] IDX_PAT3 = 4'h9;
  localparam logic [3:0] IDX_CTRL = 4'hA;
  localparam logic [3:0] IDX_COUNT = 4'hB;
  localparam logic [3:0] IDX_NONE = 4'hF;
  localparam int NUM_STORED = 11;

  // Reset value of every stored register.
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // Fields of the pixel combine control register.
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_MODE_LSB = 8;
  localparam int CTRL_PAT_TRANSP = 10;
  localparam int CTRL_SRC_TRANSP = 11;

  // Pattern modes held in control bits 9:8.
  typedef enum logic [1:0] {
    PSPP_PAT_SOLID = 2'b00,
    PSPP_PAT_MONO = 2'b01,
    PSPP_PAT_DITHER = 2'b10,
    PSPP_PAT_COLOR = 2'b11
  } pspp_pat_mode_type;

endpackage

// *** hdl/pspp_ternary_op.sv ***
// Bitwise ternary raster operation over pattern, source and destination words.
// Assumes purely combinational use inside the pixel path on the core clock.
`timescale 1ns/100ps
module pspp_ternary_op #(
  parameter int WIDTH = 16
) (
  input wire logic [7:0] ternary_op_code,
  input wire logic [WIDTH-1:0] pat_word,
  input wire logic [WIDTH-1:0] src_word,
  input wire logic [WIDTH-1:0] dst_word,
  output logic [WIDTH-1:0] result_word
);

  // Each bit position is combined on its own, so depth does not matter.
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++)
    begin : g_bit
      // The triple forms the index; the pattern bit is the top index bit.
      assign result_word[b] =
        ternary_op_code[{pat_word[b], src_word[b], dst_word[b]}];
    end
  endgenerate

endmodule

// *** sim/pspp_pixel_path_sva.sv ***
// Checker of the pixel combine datapath, bound to its top module.
// Assumes it sees only the top ports, all on the single core clock.
`timescale 1ns/100ps
module pspp_pixel_path_sva #(
  parameter int PIXEL_W = 16
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic px_valid,
  input wire logic px_bpp16,
  input wire logic px_src_expand,
  input wire logic px_src_bit,
  input wire logic [PIXEL_W-1:0] px_src_pixel,
  input wire logic [PIXEL_W-1:0] px_dst_pixel,
  input wire logic out_valid,
  input wire logic out_write,
  input wire logic [PIXEL_W-1:0] out_pixel
);
  // Shadow copies of the control and source colour registers.
  logic [31:0] ctrl_q;
  logic [31:0] scol_q;
  // Follows register writes byte by byte, as the design must.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= 32'h0000_0000;
      scol_q <= 32'h0000_0000;
    end
    else if (reg_wr)
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (reg_be[k] && reg_addr == pspp_pkg::OFS_COMBINE_CTRL)
        begin
          ctrl_q[8*k+:8] <= reg_wdata[8*k+:8];
        end
        if (reg_be[k] && reg_addr == pspp_pkg::OFS_SRC_COLORS)
        begin
          scol_q[8*k+:8] <= reg_wdata[8*k+:8];
        end
      end
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // A read is answered on the following edge.
  sequence rd_answer;
    ##1 reg_rvalid;
  endsequence
  rd_answer_a: assert property (reg_rd |-> rd_answer)
    else $error("read got no answer");
  rd_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without a read");
  unmapped_zero_a: assert property (reg_rd && (reg_addr < 16'h8100
    || reg_addr > 16'h82FF || reg_addr == 16'h8118) |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  px_answer_a: assert property (px_valid |=> out_valid)
    else $error("pixel result late");
  idle_hold_a: assert property (!px_valid |=> !out_valid && $stable(out_pixel))
    else $error("output moved while idle");
  src_transp_a: assert property (px_valid && ctrl_q[11] && px_src_expand
    && !px_src_bit |=> !out_write)
    else $error("transparent source pixel written");
  write_valid_a: assert property (out_write |-> out_valid)
    else $error("write without a result");
  op_invert_a: assert property (px_valid && px_bpp16 && ctrl_q[7:0] == 8'h55
    |=> out_pixel == ~$past(px_dst_pixel))
    else $error("inverted destination wrong");
  src_copy_a: assert property (px_valid && px_bpp16 && !px_src_expand
    && ctrl_q[7:0] == 8'hCC |=> out_pixel == $past(px_src_pixel))
    else $error("source copy wrong");
  // Colours are taken as they stood when the pixel was accepted.
  src_expand_a: assert property (px_valid && px_bpp16 && px_src_expand
    && ctrl_q[7:0] == 8'hCC && !ctrl_q[11] && !ctrl_q[10]
    |=> out_write && out_pixel == ($past(px_src_bit) ? $past(scol_q[31:16])
    : $past(scol_q[15:0])))
    else $error("source expansion colour wrong");
  byte_mask_a: assert property (px_valid && !px_bpp16 |=> out_pixel[15:8] == 8'h00)
    else $error("upper byte set at 8 bpp");
endmodule

bind pspp_pixel_path pspp_pixel_path_sva #(.PIXEL_W(PIXEL_W)) u_sva (.core_clk, .rstn,
  .reg_addr, .reg_wr, .reg_rd, .reg_be, .reg_wdata, .reg_rdata, .reg_rvalid, .px_valid,
  .px_bpp16, .px_src_expand, .px_src_bit, .px_src_pixel, .px_dst_pixel, .out_valid,
  .out_write, .out_pixel);

// *** sim/pspp_pixel_path_tb_top.sv ***
// Self-checking bench for the pixel combine datapath.
// Assumes the package, design and checker are compiled before it.
`timescale 1ns/100ps
module pspp_pixel_path_tb_top;
  logic core_clk;
  logic rstn;
  logic [15:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [3:0] reg_be;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic [31:0] dst_c;
  logic [31:0] size_c;
  logic [31:0] src_c;
  logic px_valid;
  logic [2:0] px_col;
  logic [2:0] px_row;
  logic px_bpp16;
  logic px_src_expand;
  logic px_src_bit;
  logic [15:0] px_src_pixel;
  logic [15:0] px_dst_pixel;
  logic out_valid;
  logic out_write;
  logic [15:0] out_pixel;
  logic [127:0] pv;
  logic [7:0] ops [8] = '{8'hF0, 8'hCC, 8'h5A, 8'h66, 8'h55, 8'h00, 8'hFF, 8'hE8};
  int n_fail;
  int checks_done;
  int n_wr;
  pspp_pixel_path #(.PIXEL_W(16)) u_dut (.core_clk, .rstn, .reg_addr, .reg_wr, .reg_rd,
    .reg_be, .reg_wdata, .reg_rdata, .reg_rvalid, .destination_start_coords(dst_c),
    .size_or_vector_length(size_c), .source_coords_or_errors(src_c), .px_valid, .px_col,
    .px_row, .px_bpp16, .px_src_expand, .px_src_bit, .px_src_pixel, .px_dst_pixel,
    .out_valid, .out_write, .out_pixel);
  // Makes the 50 MHz core clock.
  initial
  begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One register write, strobe held for one edge.
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge core_clk);
    reg_wr = 1'h0;
  endtask
  // One register read; the answer stands in the next cycle.
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge core_clk);
    reg_rd = 1'h0;
    chk("rvalid", 32'h1, {31'h0, reg_rvalid});
    chk("rdata", exp, reg_rdata);
  endtask
  // One pixel; source and destination words are set beforehand.
  task automatic pix(input logic [2:0] c, input logic [2:0] r, input logic b16,
    input logic sx, input logic sb, input logic [15:0] e, input logic w);
    @(negedge core_clk);
    px_col = c;
    px_row = r;
    px_bpp16 = b16;
    px_src_expand = sx;
    px_src_bit = sb;
    px_valid = 1'h1;
    @(negedge core_clk);
    px_valid = 1'h0;
    chk("out_valid", 32'h1, {31'h0, out_valid});
    chk("out_write", {31'h0, w}, {31'h0, out_write});
    if (w)
    begin
      chk("out_pixel", {16'h0, e}, {16'h0, out_pixel});
      n_wr++;
    end
  endtask
  // Bitwise ternary operation worked out from the truth table.
  function automatic logic [15:0] ternary_ref(input logic [7:0] op, input logic [15:0] p, s, d);
    logic [15:0] o;
    for (int i = 0; i < 16; i++)
    begin
      o[i] = op[{p[i], s[i], d[i]}];
    end
    return o;
  endfunction
  // Cuts a hang short; the tests need well under a thousand cycles.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    end_of_test();
  end
  // Main sequence of tests.
  initial
  begin
    logic [15:0] e;
    {reg_addr, reg_wr, reg_rd, reg_wdata, px_valid, px_col, px_row} = '0;
    {px_bpp16, px_src_expand, px_src_bit, px_src_pixel, px_dst_pixel} = '0;
    reg_be = 4'hF;
    rstn = 1'h0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'h1;
    // Reset values, read-back and holes inside the window.
    for (int a = 'h8100; a < 'h8130; a += 4)
    begin
      rd(16'(a), 32'h0);
      wr(16'(a), {16'(a), 16'hC3A5});
      rd(16'(a), (a == 'h8118 || a == 'h811C) ? 32'h0 : {16'(a), 16'hC3A5});
    end
    chk("dst", 32'h8100_C3A5, dst_c);
    chk("size", 32'h8104_C3A5, size_c);
    chk("src", 32'h8108_C3A5, src_c);
    // Only the enabled lanes change: colour one at 810Eh is replaced alone.
    reg_be = 4'hC;
    wr(16'h810C, 32'hBEEF_FFFF);
    reg_be = 4'hF;
    rd(16'h810C, 32'hBEEF_C3A5);
    wr(16'h8300, 32'hFFFF_FFFF);
    rd(16'h8300, 32'h0);
    rd(16'h80FC, 32'h0);
    wr(16'h8220, 32'hFFFF_FFFF);
    rd(16'h8220, 32'h0);
    // Every listed operation code at both depths, solid pattern.
    wr(16'h8110, 32'h1234_0F0F);
    px_src_pixel = 16'h3333;
    px_dst_pixel = 16'h5555;
    foreach (ops[i])
    begin
      wr(16'h8200, {24'h0, ops[i]});
      e = ternary_ref(ops[i], 16'h0F0F, 16'h3333, 16'h5555);
      pix(3'h0, 3'h0, 1'h1, 1'h0, 1'h0, e, 1'h1);
      pix(3'h0, 3'h0, 1'h0, 1'h0, 1'h0, e & 16'h00FF, 1'h1);
    end
    // Source expansion, then with source transparency.
    wr(16'h810C, 32'hBEEF_1234);
    wr(16'h8200, 32'h0000_00CC);
    pix(3'h0, 3'h0, 1'h1, 1'h1, 1'h0, 16'h1234, 1'h1);
    pix(3'h0, 3'h0, 1'h1, 1'h1, 1'h1, 16'hBEEF, 1'h1);
    wr(16'h8200, 32'h0000_08CC);
    pix(3'h0, 3'h0, 1'h1, 1'h1, 1'h0, 16'h0, 1'h0);
    pix(3'h0, 3'h0, 1'h1, 1'h1, 1'h1, 16'hBEEF, 1'h1);
    // Monochrome pattern, leftmost bit set, then transparent.
    wr(16'h8120, 32'h0000_0080);
    wr(16'h8200, 32'h0000_01F0);
    pix(3'h0, 3'h0, 1'h1, 1'h0, 1'h0, 16'h1234, 1'h1);
    pix(3'h1, 3'h0, 1'h1, 1'h0, 1'h0, 16'h0F0F, 1'h1);
    wr(16'h8200, 32'h0000_05F0);
    pix(3'h1, 3'h0, 1'h1, 1'h0, 1'h0, 16'h0, 1'h0);
    pix(3'h0, 3'h0, 1'h1, 1'h0, 1'h0, 16'h1234, 1'h1);
    // Dither pattern choosing among four colours.
    wr(16'h8120, 32'h4411_00AA);
    wr(16'h8124, 32'h1155_00AA);
    wr(16'h8114, 32'hCCCC_AAAA);
    wr(16'h8200, 32'h0000_02F0);
    pix(3'h0, 3'h0, 1'h1, 1'h0, 1'h0, 16'h1234, 1'h1);
    pix(3'h1, 3'h0, 1'h1, 1'h0, 1'h0, 16'h0F0F, 1'h1);
    pix(3'h1, 3'h1, 1'h1, 1'h0, 1'h0, 16'hAAAA, 1'h1);
    pix(3'h3, 3'h3, 1'h1, 1'h0, 1'h0, 16'hCCCC, 1'h1);
    // Colour pattern, one row, at both depths.
    pv = 128'h2468_ACE0_1357_9BDF_0FED_CBA9_8765_4321;
    for (int k = 0; k < 4; k++)
    begin
      wr(16'(16'h8120 + 4 * k), pv[32*k+:32]);
    end
    wr(16'h8200, 32'h0000_03F0);
    for (int c = 0; c < 8; c++)
    begin
      pix(3'(c), 3'h2, 1'h1, 1'h0, 1'h0, pv[16*c+:16], 1'h1);
      pix(3'(c), 3'h2, 1'h0, 1'h0, 1'h0, {8'h0, pv[8*c+:8]}, 1'h1);
    end
    wr(16'h8120, 32'h5555_AAAA);
    pix(3'h0, 3'h5, 1'h1, 1'h0, 1'h0, 16'hAAAA, 1'h1);
    rd(16'h8220, 32'(n_wr));
    // A second reset in mid-run clears every register and the count.
    @(negedge core_clk);
    rstn = 1'h0;
    repeat (2) @(negedge core_clk);
    rstn = 1'h1;
    chk("dst after reset", 32'h0, dst_c);
    rd(16'h8200, 32'h0);
    rd(16'h8220, 32'h0);
    end_of_test();
  end
endmodule
